// >>> include/nvsc_regs.vh
// Constants for the host-side controller of the nonvolatile static RAM
// Operation
// - Reads 0000,1555,0AAA,1FFF,10F0,0F0F in order start a store.
// - Same five reads then 0F0E start a recall.
// - Host keeps write strobe high during all six unlock reads.
// - Unlock paced by chip-select reads; output enable level irrelevant.
// - Host holds address stable for the whole write.
// - Output enable low in write disables drivers; host keeps it high.
// - System avoids a held write state when power-up recall ends.
`ifndef NVSC_REGS_VH
`define NVSC_REGS_VH

// ----------------------------------------
// Unlock addresses
// ----------------------------------------
`define NVSC_UNLOCK_A0     13'h0000
`define NVSC_UNLOCK_A1     13'h1555
`define NVSC_UNLOCK_A2     13'h0aaa
`define NVSC_UNLOCK_A3     13'h1fff
`define NVSC_UNLOCK_A4     13'h10f0
`define NVSC_UNLOCK_STORE  13'h0f0f
`define NVSC_UNLOCK_RECALL 13'h0f0e

// ----------------------------------------
// Timing, in ms / us / ns and derived 40 MHz cycles
// ----------------------------------------
`define NVSC_CLK_NS          25
`define NVSC_STORE_TIME_MS   10
// Cycle counts are sized to their counters: 10 ms, 20 us, 550 us and 55 ns at 25 ns
`define NVSC_STORE_CYC       20'h61a80
`define NVSC_RECALL_TIME_US  20
`define NVSC_RECALL_CYC      20'h00320
`define NVSC_PWRUP_TIME_US   550
`define NVSC_PWRUP_CYC       20'h055f0
`define NVSC_ACC_NS          55
`define NVSC_ACC_CYC         4'h3
`define NVSC_PHASE_CYC       4'h4
`define NVSC_CNT_W           20

`endif

// >>> logic/nvsc_seq_rom.v
// Unlock address table with registered read data
`timescale 1ns/1ps

module nvsc_seq_rom (
	input  wire        clk_i,
	input  wire [2:0]  idx_i,
	input  wire        recall_i,
	output reg  [12:0] addr_o
);
`include "nvsc_regs.vh"

	// Registered lookup keeps the address pins glitch free
	always @(posedge clk_i) begin
		case (idx_i)
			3'h0: addr_o <= `NVSC_UNLOCK_A0;
			3'h1: addr_o <= `NVSC_UNLOCK_A1;
			3'h2: addr_o <= `NVSC_UNLOCK_A2;
			3'h3: addr_o <= `NVSC_UNLOCK_A3;
			3'h4: addr_o <= `NVSC_UNLOCK_A4;
			default: addr_o <= recall_i ? `NVSC_UNLOCK_RECALL : `NVSC_UNLOCK_STORE;
		endcase
	end
endmodule

// >>> logic/nvsc_host.v
// Host controller driving the static RAM pins: reads, writes, software store and recall
`timescale 1ns/1ps

module nvsc_host (
	input  wire        CLOCK_I,
	input  wire        RST_I,
	input  wire        REQ_VALID_I,
	input  wire [1:0]  REQ_OP_I,
	input  wire [12:0] REQ_ADDR_I,
	input  wire [7:0]  REQ_WDATA_I,
	output reg         REQ_READY_O,
	output reg         RSP_VALID_O,
	output reg  [7:0]  RSP_RDATA_O,
	output reg         NV_BUSY_O,
	output reg  [12:0] BYTE_SEL_O,
	output reg         CHIP_SEL_N_O,
	output reg         WR_STB_N_O,
	output reg         OUT_EN_N_O,
	input  wire [7:0]  IO_BUS_I,
	output reg  [7:0]  IO_BUS_O,
	output reg         IO_BUS_OE_N_O,
	input  wire        NV_BUSY_REQ_N_I,
	output reg         NV_BUSY_REQ_N_O,
	output reg         NV_BUSY_REQ_OE_N_O
);
`include "nvsc_regs.vh"

	// ----------------------------------------
	// Operation codes and states
	// ----------------------------------------
	localparam [1:0] OP_READ   = 2'h0;
	localparam [1:0] OP_WRITE  = 2'h1;
	localparam [1:0] OP_STORE  = 2'h2;
	localparam [1:0] OP_RECALL = 2'h3;

	// One-hot sequencer states; GAP is the dead cycle between chip-select pulses,
	// so every unlock read reaches the device as a separate falling select edge
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_SET  = 6'h02;
	localparam [5:0] ST_ACT  = 6'h04;
	localparam [5:0] ST_END  = 6'h08;
	localparam [5:0] ST_GAP  = 6'h10;
	localparam [5:0] ST_WAIT = 6'h20;

	// Counts are whole 25 ns cycles rounded up, so every wait is at least its minimum
	localparam [`NVSC_CNT_W-1:0] STORE_CYC  = `NVSC_STORE_CYC;
	localparam [`NVSC_CNT_W-1:0] RECALL_CYC = `NVSC_RECALL_CYC;
	localparam [`NVSC_CNT_W-1:0] PWRUP_CYC  = `NVSC_PWRUP_CYC;
	localparam [3:0]             ACC_CYC    = `NVSC_ACC_CYC;

	// Sequencer registers
	reg  [5:0]            state_q;
	reg  [1:0]            op_q;
	reg  [12:0]           addr_q;
	reg  [7:0]            wdata_q;
	reg  [2:0]            step_q;
	reg  [3:0]            ph_q;
	reg  [`NVSC_CNT_W-1:0] wait_q;
	reg                   busy_s1_q;
	reg                   busy_q;
	wire [12:0]           rom_addr;
	wire                  unlock;

	// Store and recall both run as six unlock reads
	assign unlock = (op_q == OP_STORE) || (op_q == OP_RECALL);

	// ----------------------------------------
	// Unlock address table
	// ----------------------------------------
	// The table answers one clock late, so the index is advanced a cycle early
	nvsc_seq_rom u_rom (
		.clk_i    (CLOCK_I),
		.idx_i    (step_q),
		.recall_i (op_q == OP_RECALL),
		.addr_o   (rom_addr)
	);

	// ----------------------------------------
	// Busy pin synchroniser
	// ----------------------------------------
	// Busy pin is taken in through two flops before any decision uses it
	// Only the second flop is read, so a pin edge near the clock cannot split decisions
	always @(posedge CLOCK_I) begin
		if (RST_I) begin
			busy_s1_q <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			busy_s1_q <= ~NV_BUSY_REQ_N_I;
			busy_q    <= busy_s1_q;
		end
	end

	// ----------------------------------------
	// Main access sequencer
	// ----------------------------------------
	// Limitation: a store that the device starts on supply loss is noticed only in idle,
	// through the busy pin, so an access already running is left to finish on its own.
	// Unlock reads are whole chip-select pulses with no other access between them,
	// so the device never sees an intervening cycle that would abandon the sequence.
	always @(posedge CLOCK_I) begin
		if (RST_I) begin
			state_q            <= ST_IDLE;
			op_q               <= OP_READ;
			addr_q             <= 13'h0000;
			wdata_q            <= 8'h00;
			step_q             <= 3'h0;
			ph_q               <= 4'h0;
			wait_q             <= PWRUP_CYC;
			REQ_READY_O        <= 1'b0;
			RSP_VALID_O        <= 1'b0;
			RSP_RDATA_O        <= 8'h00;
			// Busy until the device's own power-up recall is surely over
			NV_BUSY_O          <= 1'b1;
			BYTE_SEL_O         <= 13'h0000;
			CHIP_SEL_N_O       <= 1'b1;
			WR_STB_N_O         <= 1'b1;
			OUT_EN_N_O         <= 1'b1;
			IO_BUS_O           <= 8'h00;
			IO_BUS_OE_N_O      <= 1'b1;
			NV_BUSY_REQ_N_O    <= 1'b0;
			NV_BUSY_REQ_OE_N_O <= 1'b1; // Never pull the pin; observe only
		end else begin
			// Response is a one-cycle pulse unless a state raises it below
			RSP_VALID_O <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// Hold off while the device is busy storing
					// A refused request is simply left standing until ready returns
					REQ_READY_O <= ~busy_q;
					NV_BUSY_O   <= busy_q;
					if (REQ_VALID_I && REQ_READY_O && !busy_q) begin
						REQ_READY_O <= 1'b0;
						NV_BUSY_O   <= 1'b1;
						op_q        <= REQ_OP_I;
						addr_q      <= REQ_ADDR_I;
						wdata_q     <= REQ_WDATA_I;
						step_q      <= 3'h0;
						state_q     <= ST_SET;
					end
				end
				ST_SET: begin
					// Address settles with both strobes high
					// Address changes only here, with select high, so no access sees it move
					BYTE_SEL_O   <= unlock ? rom_addr : addr_q;
					CHIP_SEL_N_O <= 1'b1;
					WR_STB_N_O   <= 1'b1;
					ph_q         <= 4'h0;
					// Output enable only for reads, so the two drivers never meet on the bus
					if (op_q == OP_WRITE) begin
						IO_BUS_O      <= wdata_q;
						IO_BUS_OE_N_O <= 1'b0;
						OUT_EN_N_O    <= 1'b1;
					end else begin
						IO_BUS_OE_N_O <= 1'b1;
						OUT_EN_N_O    <= 1'b0;
					end
					state_q <= ST_ACT;
				end
				ST_ACT: begin
					// Chip select paces the cycle; write strobe only for writes
					// Address and data are left alone here to stay still
					CHIP_SEL_N_O <= 1'b0;
					WR_STB_N_O   <= (op_q != OP_WRITE);
					ph_q         <= ph_q + 4'h1;
					if (ph_q == ACC_CYC) begin
						state_q <= ST_END;
					end
				end
				ST_END: begin
					// Rising select ends the write; data still held this edge
					// Read data is taken while select and output enable are still low
					CHIP_SEL_N_O <= 1'b1;
					WR_STB_N_O   <= 1'b1;
					OUT_EN_N_O   <= 1'b1;
					if (op_q == OP_READ) begin
						RSP_RDATA_O <= IO_BUS_I;
					end
					// Step moves here so the table's registered output is ready by SET
					if (unlock) begin
						step_q <= step_q + 3'h1;
					end
					ph_q    <= 4'h0;
					state_q <= ST_GAP;
				end
				ST_GAP: begin
					// Data held one more cycle past the strobe for hold time
					// It also keeps the select high for a full cycle between unlock reads
					IO_BUS_OE_N_O <= 1'b1;
					if (unlock && step_q != 3'h6) begin
						state_q <= ST_SET;
					end else if (unlock) begin
						// Index parks at zero so the next unlock opens at its first address
						step_q  <= 3'h0;
						wait_q  <= (op_q == OP_STORE) ? STORE_CYC : RECALL_CYC;
						state_q <= ST_WAIT;
					end else begin
						RSP_VALID_O <= 1'b1;
						state_q     <= ST_IDLE;
					end
				end
				ST_WAIT: begin
					// No pin activity while the device runs its nonvolatile cycle
					// Trade-off: the worst-case time is waited instead of watching the busy pin
					wait_q <= wait_q - 20'h00001;
					if (wait_q == 20'h00001) begin
						RSP_VALID_O <= 1'b1;
						state_q     <= ST_IDLE;
					end
				end
				// An illegal state code falls back to idle
				default: state_q <= ST_IDLE;
			endcase
			// ----------------------------------------
			// Power-up recall wait
			// ----------------------------------------
			// Power-up wait shares the counter before the first access
			if (state_q == ST_IDLE && wait_q != 20'h00000) begin
				wait_q      <= wait_q - 20'h00001;
				REQ_READY_O <= 1'b0;
				NV_BUSY_O   <= 1'b1;
			end
		end
	end
endmodule

// >>> dv/nvsc_chk.sv
// Port checker for the host controller
`timescale 1ns/1ps
module nvsc_chk (
	input wire logic        CLOCK_I,
	input wire logic        RST_I,
	input wire logic        REQ_VALID_I,
	input wire logic [1:0]  REQ_OP_I,
	input wire logic        REQ_READY_O,
	input wire logic        RSP_VALID_O,
	input wire logic [12:0] BYTE_SEL_O,
	input wire logic        CHIP_SEL_N_O,
	input wire logic        WR_STB_N_O,
	input wire logic        OUT_EN_N_O,
	input wire logic [7:0]  IO_BUS_O,
	input wire logic        IO_BUS_OE_N_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	// A request is taken on a ready edge
	wire take = REQ_VALID_I && REQ_READY_O;
	a_take_drops: assert property (
		take |=> !REQ_READY_O) else $error("ready held after take");
	a_read_lat: assert property (
		take && REQ_OP_I == 2'h0 |-> ##[8:9] RSP_VALID_O) else $error("read late");
	a_rsp_pulse: assert property (
		RSP_VALID_O |=> !RSP_VALID_O) else $error("response too long");
	a_idle_pins: assert property (
		REQ_READY_O |-> CHIP_SEL_N_O && WR_STB_N_O && IO_BUS_OE_N_O) else $error("idle pins");
	a_write_pins: assert property (
		!WR_STB_N_O |-> OUT_EN_N_O && !CHIP_SEL_N_O && !IO_BUS_OE_N_O) else $error("write pins");
	a_write_hold: assert property (
		!WR_STB_N_O |=> $stable(BYTE_SEL_O) && $stable(IO_BUS_O) && !IO_BUS_OE_N_O)
		else $error("write end moved");
	a_read_oe: assert property (
		!CHIP_SEL_N_O && WR_STB_N_O |-> !OUT_EN_N_O) else $error("read without oe");
	a_unlock_reads: assert property (
		take && REQ_OP_I[1] |=> WR_STB_N_O [*8]) else $error("write in unlock");
	c_read: cover property (take && REQ_OP_I == 2'h0);
	c_write: cover property (take && REQ_OP_I == 2'h1);
	c_recall: cover property (take && REQ_OP_I == 2'h3);
	c_store: cover property (take && REQ_OP_I == 2'h2);
endmodule
bind nvsc_host nvsc_chk chk_u (.*);

// >>> dv/nvsc_mem_model.sv
// Static RAM with shadow array, unlock detector and busy pin
`timescale 1ns/1ps
module nvsc_mem_model #(
	parameter int STORE_NS = 20000
) (
	input wire logic [12:0] byte_sel_i,
	input wire logic        chip_sel_n_i,
	input wire logic        wr_stb_n_i,
	input wire logic        out_en_n_i,
	input wire logic [7:0]  host_data_i,
	input wire logic        host_oe_n_i,
	input wire logic        power_trip_i,
	output logic     [7:0]  dev_data_o,
	output logic            busy_n_o = 1'b1,
	output int              store_cnt_o = 0
);
	logic [7:0]  sram [0:8191];
	logic [7:0]  nv   [0:8191];
	logic [12:0] seq  [0:4] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
	logic [12:0] wa;
	logic [7:0]  wd;
	logic        wr_on = 1'b0;
	logic        dirty = 1'b0;
	int          step = 0;
	// Power-up recall fills the cells from the shadow pattern
	initial for (int i = 0; i < 8192; i++) begin
		nv[i] = i[7:0] ^ 8'h5a;
		sram[i] = nv[i];
	end
	// Inverse when not reading, so stale data never looks valid
	assign dev_data_o = (!chip_sel_n_i && !out_en_n_i && wr_stb_n_i && busy_n_o) ?
		sram[byte_sel_i] : ~sram[byte_sel_i];
	// Byte committed as it stands when the write ends
	always @* begin
		if (!chip_sel_n_i && !wr_stb_n_i && busy_n_o) begin
			wa = byte_sel_i;
			wd = host_oe_n_i ? 8'hxx : host_data_i;
			wr_on = 1'b1;
			step = 0;
		end else if (wr_on) begin
			sram[wa] = wd;
			wr_on = 1'b0;
			dirty = 1'b1;
		end
	end
	// Select falling edges pace the unlock; output enable is ignored
	always @(negedge chip_sel_n_i) begin
		if (wr_stb_n_i && busy_n_o) begin
			if (step < 5 && byte_sel_i == seq[step]) step++;
			else if (step == 5 && byte_sel_i == 13'h0f0f) begin
				step = 0;
				busy_n_o = 1'b0;
				store_cnt_o++;
				dirty = 1'b0;
				for (int i = 0; i < 8192; i++) nv[i] = 8'hff;
				for (int i = 0; i < 8192; i++) nv[i] = sram[i];
				#STORE_NS busy_n_o = 1'b1;
			end else if (step == 5 && byte_sel_i == 13'h0f0e) begin
				step = 0;
				for (int i = 0; i < 8192; i++) sram[i] = 8'h00;
				for (int i = 0; i < 8192; i++) sram[i] = nv[i];
				dirty = 1'b0;
				#10000;
			end else step = (byte_sel_i == 13'h0000) ? 1 : 0;
		end
	end
	// Supply trip: busy pulse, with a store inside it only when written since the last nonvolatile cycle
	always @(posedge power_trip_i) begin
		#110 busy_n_o = 1'b0;
		#1000;
		if (dirty) begin
			dirty = 1'b0;
			store_cnt_o++;
			for (int i = 0; i < 8192; i++) nv[i] = sram[i];
			#STORE_NS;
		end
		busy_n_o = 1'b1;
	end
endmodule

// >>> dv/nvsc_host_test.sv
// Self-checking bench for the host controller
`timescale 1ns/1ps
module nvsc_host_test;
	logic        CLOCK_I = 1'b0;
	logic        RST_I = 1'b1;
	logic        vld = 1'b0;
	logic [1:0]  op = 2'h0;
	logic [12:0] adr = 13'h0000;
	logic [7:0]  wdat = 8'h00;
	logic        trip = 1'b0;
	wire         rdy, rsp, nvb, cs_n, we_n, oe_n, boe_n, hb, hboe_n, dbn;
	wire  [7:0]  rd, bo, dd;
	wire  [12:0] sel;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          scnt;
	logic [9:0]  exp_q [$];
	logic [9:0]  e;
	logic [7:0]  ref_mem [int];
	logic [12:0] a;
	logic [7:0]  d;
	always #12.5 CLOCK_I = ~CLOCK_I;
	nvsc_host dut_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .REQ_VALID_I(vld), .REQ_OP_I(op),
		.REQ_ADDR_I(adr), .REQ_WDATA_I(wdat), .REQ_READY_O(rdy), .RSP_VALID_O(rsp),
		.RSP_RDATA_O(rd), .NV_BUSY_O(nvb), .BYTE_SEL_O(sel), .CHIP_SEL_N_O(cs_n),
		.WR_STB_N_O(we_n), .OUT_EN_N_O(oe_n), .IO_BUS_I(boe_n ? dd : bo), .IO_BUS_O(bo),
		.IO_BUS_OE_N_O(boe_n), .NV_BUSY_REQ_N_I(dbn & (hboe_n | hb)),
		.NV_BUSY_REQ_N_O(hb), .NV_BUSY_REQ_OE_N_O(hboe_n));
	nvsc_mem_model mem_u (.byte_sel_i(sel), .chip_sel_n_i(cs_n), .wr_stb_n_i(we_n),
		.out_en_n_i(oe_n), .host_data_i(bo), .host_oe_n_i(boe_n), .dev_data_o(dd),
		.power_trip_i(trip), .busy_n_o(dbn), .store_cnt_o(scnt));
	task automatic end_sim;
		if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Unwritten bytes hold the recalled shadow pattern
	function automatic logic [7:0] model_byte(input logic [12:0] x);
		return ref_mem.exists(x) ? ref_mem[x] : x[7:0] ^ 8'h5a;
	endfunction
	// Waits for ready under a bound, then offers one request
	task automatic req(input logic [1:0] o, input logic [12:0] ad, input logic [7:0] wd);
		int n;
		n = 0;
		while (rdy !== 1'b1) begin
			@(posedge CLOCK_I);
			#1;
			n++;
			if (n > 30000) begin
				check(8'h00, 8'hff);
				end_sim();
			end
		end
		@(posedge CLOCK_I);
		vld <= 1'b1;
		op <= o;
		adr <= ad;
		wdat <= wd;
		exp_q.push_back({o, model_byte(ad)});
		if (o == 2'h1) ref_mem[ad] = wd;
		if (o == 2'h3) ref_mem.delete();
		@(posedge CLOCK_I);
		vld <= 1'b0;
		#1;
	endtask
	// Each response retires the oldest note; reads compare data
	always @(posedge CLOCK_I) begin
		if (rsp === 1'b1) begin
			if (exp_q.size() == 0) check(8'h00, 8'hff);
			else begin
				e = exp_q.pop_front();
				if (e[9:8] == 2'h0) check(rd, e[7:0]);
			end
		end
	end
	initial begin
		void'($urandom(35563));
		repeat (3) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		// Two writes to one byte, the later must win; neighbour read too
		for (int i = 0; i < 6; i++) begin
			a = 13'($urandom);
			d = 8'($urandom);
			req(2'h1, a, ~d);
			req(2'h1, a, d);
			req(2'h0, a, 8'h00);
			req(2'h0, a ^ 13'h0001, 8'h00);
		end
		req(2'h3, 13'h0000, 8'h00);
		req(2'h0, a, 8'h00);
		// Supply trip with nothing written since the recall: busy pulse, no store
		repeat (12) @(posedge CLOCK_I);
		trip <= 1'b1;
		repeat (10) @(posedge CLOCK_I);
		check({rdy, nvb}, 8'h01);
		repeat (60) @(posedge CLOCK_I);
		trip <= 1'b0;
		check({rdy, nvb}, 8'h02);
		check(8'(scnt), 8'h00);
		req(2'h1, 13'h0123, 8'h3c);
		// Supply trip after a write: the device stores by itself
		repeat (12) @(posedge CLOCK_I);
		trip <= 1'b1;
		repeat (100) @(posedge CLOCK_I);
		trip <= 1'b0;
		check(8'(scnt), 8'h01);
		check({rdy, nvb}, 8'h01);
		req(2'h2, 13'h0000, 8'h00);
		repeat (80) @(posedge CLOCK_I);
		check(8'(scnt), 8'h02);
		check(mem_u.nv[13'h0123], 8'h3c);
		check({rdy, nvb}, 8'h01);
		check({6'h00, hboe_n, hb}, 8'h02);
		end_sim();
	end
endmodule
